// [common/tsc_pkg.sv]
// Shared constants, field layouts and carrier types for the temperature sensor control block.
package tsc_pkg;

	// Clock rate and bus time-out.
	localparam int CORE_CLK_HZ    = 20_000_000;
	localparam int TIMEOUT_MS     = 54;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CORE_CLK_HZ / 1000);

	// Register select codes carried in the low pointer bits.
	localparam logic [1:0] SEL_TEMP  = 2'h0;
	localparam logic [1:0] SEL_CFG   = 2'h1;
	localparam logic [1:0] SEL_TLOW  = 2'h2;
	localparam logic [1:0] SEL_THIGH = 2'h3;

	// Power-up values.
	localparam logic [7:0]  PTR_RESET   = 8'h00;
	localparam logic [7:0]  CFG_RESET   = 8'h00;
	localparam logic [11:0] TEMP_RESET  = 12'h000;
	localparam logic [11:0] TLOW_RESET  = 12'h4b0;
	localparam logic [11:0] THIGH_RESET = 12'h500;

	// Configuration byte field positions.
	localparam int CFG_OS     = 7;
	localparam int CFG_RES_HI = 6;
	localparam int CFG_RES_LO = 5;
	localparam int CFG_FLT_HI = 4;
	localparam int CFG_FLT_LO = 3;
	localparam int CFG_POL    = 2;
	localparam int CFG_TM     = 1;
	localparam int CFG_SD     = 0;

	// Bus addresses and command bytes.
	localparam logic [3:0] ADDR_BASE     = 4'h9;
	localparam logic [7:0] ARA_BYTE      = 8'h19;
	localparam logic [7:0] GC_BYTE       = 8'h00;
	localparam logic [7:0] GC_CMD_LATCH  = 8'h04;
	localparam logic [7:0] GC_CMD_RESET  = 8'h06;
	localparam logic [4:0] HS_CODE_PFX   = 5'h01;

	typedef enum logic [2:0] {EV_NONE, EV_WRITE, EV_READ, EV_ARA_WON, EV_GC_RESET} tsc_ev_kind_type;
	typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_RX, LK_ACK, LK_TX, LK_MACK} tsc_link_state_type;
	typedef enum logic [1:0] {ROLE_WRITE, ROLE_READ, ROLE_ARA, ROLE_GC} tsc_role_type;
	typedef enum logic {CV_IDLE, CV_BUSY} tsc_conv_state_type;

	// Event sent from the bus side to the core side.
	typedef struct packed {
		tsc_ev_kind_type kind;
		logic [1:0]      sel;
		logic [15:0]     data;
	} tsc_event_type;

	// Register image published from the core side to the bus side.
	typedef struct packed {
		logic [11:0] temp;
		logic [7:0]  cfg;
		logic [11:0] tlow;
		logic [11:0] thigh;
		logic        alert;
		logic        cause;
	} tsc_snapshot_type;

	// Consecutive faults needed for each fault-count code.
	function automatic logic [2:0] fault_need(input logic [1:0] code);
		case (code)
			2'h0:    return 3'h1;
			2'h1:    return 3'h2;
			2'h2:    return 3'h4;
			default: return 3'h6;
		endcase
	endfunction

endpackage

// [rtl/tsc_sync.sv]
// Two flip-flop level synchroniser for signals entering a clock domain.
module tsc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	import tsc_pkg::*;

	logic [WIDTH-1:0] stageReg;

	// The first stage is read only by the second, so metastability never reaches logic.
	always_ff @(posedge clk) begin
		stageReg <= asyncIn;
		syncOut  <= stageReg;
	end
endmodule

// [rtl/tsc_handshake.sv]
// Toggle handshake that carries one word at a time between two clock domains.
module tsc_handshake #(
	parameter int WIDTH = 8
) (
	input  wire logic             srcClk,
	input  wire logic             srcRst,
	input  wire logic             srcValid,
	input  wire logic [WIDTH-1:0] srcData,
	output logic                  srcReady,
	input  wire logic             dstClk,
	input  wire logic             dstRst,
	output logic                  dstValid,
	output logic      [WIDTH-1:0] dstData
);
	import tsc_pkg::*;

	logic             reqTglReg;
	logic             ackTglReg;
	logic [WIDTH-1:0] holdReg;
	logic             ackSync;
	logic             reqSync;

	tsc_sync #(.WIDTH(1)) ackSyncInst (.clk(srcClk), .asyncIn(ackTglReg), .syncOut(ackSync));
	tsc_sync #(.WIDTH(1)) reqSyncInst (.clk(dstClk), .asyncIn(reqTglReg), .syncOut(reqSync));

	// A new word may only be launched once the previous one has been acknowledged.
	assign srcReady = (ackSync == reqTglReg);

	// Source side holds the word stable until the far side has taken it.
	always_ff @(posedge srcClk) begin
		if (srcRst) begin
			reqTglReg <= 1'b0;
			holdReg   <= '0;
		end else if (srcValid && srcReady) begin
			reqTglReg <= ~reqTglReg;
			holdReg   <= srcData;
		end
	end

	// Destination side captures the held word when the request toggle arrives.
	always_ff @(posedge dstClk) begin
		if (dstRst) begin
			ackTglReg <= 1'b0;
			dstValid  <= 1'b0;
			dstData   <= '0;
		end else if (reqSync != ackTglReg) begin
			ackTglReg <= reqSync;
			dstValid  <= 1'b1;
			dstData   <= holdReg;
		end else begin
			dstValid  <= 1'b0;
		end
	end
endmodule

// [rtl/tsc_sensor_ctrl.sv]
// Two-wire slave front end and mode control for a digital temperature sensor.
module tsc_sensor_ctrl #(
	parameter int TIMEOUT_CYCLES = tsc_pkg::TIMEOUT_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        linkClk,
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	input  wire logic        addrPin0,
	input  wire logic        addrPin1,
	input  wire logic        addrPin2,
	output logic             hsMode,
	output logic             convStart,
	input  wire logic        convDone,
	input  wire logic [11:0] convResult,
	output logic      [1:0]  resolutionSel,
	output logic             alertPin
);
	import tsc_pkg::*;

	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

	////////////////////////////////////////////////////////////////////////////////
	// Bus side, clocked by the link clock.

	logic [6:0]         linkSync;
	logic               sclS, sdaS, linkRst, toTglS;
	logic [2:0]         pinsS;
	logic               sclPrev, sdaPrev, toTglPrev;
	logic               sclRise, sclFall, startCond, stopCond, timeoutHit;
	tsc_link_state_type state;
	tsc_role_type       role;
	logic [3:0]         bitCnt;
	logic [1:0]         byteIdx;
	logic [7:0]         shiftReg, txByte, hiByte, ptrReg, nextTx;
	logic [2:0]         pinsReg;
	logic [6:0]         myAddr;
	logic               masterAck, araWon, busFrameReg, sdaOeReg, hsModeReg;
	logic               byteDone, hsCode, gcLatch, gcResetCmd, ptrWrite;
	logic               evValidReg, evReady;
	tsc_event_type      evDataReg;
	tsc_snapshot_type   snapReg, snapIn;
	logic               snapValid;
	logic               timeoutTgl;

	tsc_sync #(.WIDTH(7)) linkSyncInst (
		.clk    (linkClk),
		.asyncIn({sclIn, sdaIn, rst, timeoutTgl, addrPin2, addrPin1, addrPin0}),
		.syncOut(linkSync)
	);

	assign {sclS, sdaS, linkRst, toTglS, pinsS} = linkSync;
	assign myAddr = {ADDR_BASE, pinsReg};

	// Bus conditions are read from the settled copies against their previous values.
	assign sclRise    = sclS & ~sclPrev;
	assign sclFall    = ~sclS & sclPrev;
	assign startCond  = sclS & sclPrev & sdaPrev & ~sdaS;
	assign stopCond   = sclS & sclPrev & ~sdaPrev & sdaS;
	assign timeoutHit = toTglS ^ toTglPrev;
	assign byteDone   = sclFall && (bitCnt == 4'h8);
	assign hsCode     = byteDone && (state == LK_ADDR) && (shiftReg[7:3] == HS_CODE_PFX);
	assign ptrWrite   = byteDone && (state == LK_RX) && (role == ROLE_WRITE) && (byteIdx == 2'h0);
	assign gcLatch    = byteDone && (state == LK_RX) && (role == ROLE_GC) && (byteIdx == 2'h0)
		&& ((shiftReg == GC_CMD_LATCH) || (shiftReg == GC_CMD_RESET));
	assign gcResetCmd = gcLatch && (shiftReg == GC_CMD_RESET);

	// Picks one byte of a register from the published image.
	function automatic logic [7:0] reg_byte(input tsc_snapshot_type s, input logic [1:0] sel,
		input logic lowHalf);
		logic [15:0] w;
		w = 16'h0000;
		case (sel)
			SEL_TEMP:  w = {s.temp, 4'h0};
			SEL_CFG:   w = {1'b0, s.cfg[6:0], 8'h00};
			SEL_TLOW:  w = {s.tlow, 4'h0};
			default:   w = {s.thigh, 4'h0};
		endcase
		return lowHalf ? w[7:0] : w[15:8];
	endfunction

	// Next register byte to send: high half after the address, then alternating halves.
	assign nextTx = reg_byte(snapReg, ptrReg[1:0], (state == LK_MACK) ? byteIdx[0] : 1'b0);

	// Edge history for condition and toggle detection.
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			sclPrev   <= 1'b1;
			sdaPrev   <= 1'b1;
			toTglPrev <= 1'b0;
		end else begin
			sclPrev   <= sclS;
			sdaPrev   <= sdaS;
			toTglPrev <= toTglS;
		end
	end

	// Address pins are caught after reset, at every start and on general call commands.
	always_ff @(posedge linkClk) begin
		if (linkRst || startCond || gcLatch) begin
			pinsReg <= pinsS;
		end
	end

	// Pointer register; a write transfer's first byte loads it and a general call reset clears it.
	always_ff @(posedge linkClk) begin
		if (linkRst || gcResetCmd) begin
			ptrReg <= PTR_RESET;
		end else if (ptrWrite) begin
			ptrReg <= shiftReg;
		end
	end

	// High-speed filter selection, held until the next stop or bus time-out.
	always_ff @(posedge linkClk) begin
		if (linkRst || stopCond || timeoutHit) begin
			hsModeReg <= 1'b0;
		end else if (hsCode) begin
			hsModeReg <= 1'b1;
		end
	end

	// Frame flag between start and stop, watched by the time-out counter.
	always_ff @(posedge linkClk) begin
		if (linkRst || stopCond || timeoutHit) begin
			busFrameReg <= 1'b0;
		end else if (startCond) begin
			busFrameReg <= 1'b1;
		end
	end

	// Byte engine: receives, acknowledges, transmits and raises events for the core.
	always_ff @(posedge linkClk) begin
		evValidReg <= 1'b0;
		if (linkRst || timeoutHit) begin
			state    <= LK_IDLE;
			sdaOeReg <= 1'b0;
			bitCnt   <= 4'h0;
			byteIdx  <= 2'h0;
			araWon   <= 1'b0;
			role     <= ROLE_WRITE;
		end else if (startCond || stopCond) begin
			if (araWon) begin
				evValidReg     <= 1'b1;
				evDataReg.kind <= EV_ARA_WON;
			end
			araWon   <= 1'b0;
			state    <= startCond ? LK_ADDR : LK_IDLE;
			sdaOeReg <= 1'b0;
			bitCnt   <= 4'h0;
			byteIdx  <= 2'h0;
		end else begin
			case (state)
				LK_ADDR, LK_RX: begin
					if (sclRise) begin
						shiftReg <= {shiftReg[6:0], sdaS};
						bitCnt   <= bitCnt + 4'h1;
					end else if (byteDone) begin
						bitCnt <= 4'h0;
						if (state == LK_RX) begin
							state    <= LK_ACK;
							sdaOeReg <= 1'b1;
							if (byteIdx != 2'h3) begin
								byteIdx <= byteIdx + 2'h1;
							end
							if (role == ROLE_WRITE && byteIdx == 2'h1) begin
								hiByte <= shiftReg;
								if (ptrReg[1:0] == SEL_CFG) begin
									evValidReg <= 1'b1;
									evDataReg  <= '{EV_WRITE, SEL_CFG, {shiftReg, 8'h00}};
								end
							end
							if (role == ROLE_WRITE && byteIdx == 2'h2
								&& ptrReg[1] == 1'b1) begin
								evValidReg <= 1'b1;
								evDataReg  <= '{EV_WRITE, ptrReg[1:0], {hiByte, shiftReg}};
							end
							if (gcResetCmd) begin
								evValidReg     <= 1'b1;
								evDataReg.kind <= EV_GC_RESET;
							end
						end else if (shiftReg[7:1] == myAddr) begin
							state    <= LK_ACK;
							sdaOeReg <= 1'b1;
							role     <= shiftReg[0] ? ROLE_READ : ROLE_WRITE;
							if (shiftReg[0]) begin
								evValidReg     <= 1'b1;
								evDataReg.kind <= EV_READ;
								evDataReg.sel  <= ptrReg[1:0];
							end
						end else if (shiftReg == ARA_BYTE && snapReg.alert) begin
							state    <= LK_ACK;
							sdaOeReg <= 1'b1;
							role     <= ROLE_ARA;
						end else if (shiftReg == GC_BYTE) begin
							state    <= LK_ACK;
							sdaOeReg <= 1'b1;
							role     <= ROLE_GC;
						end else begin
							state <= LK_IDLE;
						end
					end
				end
				LK_ACK: begin
					if (sclFall) begin
						if (role == ROLE_READ || role == ROLE_ARA) begin
							txByte   <= (role == ROLE_ARA) ? {myAddr, snapReg.cause}
								: nextTx;
							sdaOeReg <= (role == ROLE_ARA) ? ~myAddr[6] : ~nextTx[7];
							byteIdx  <= 2'h1;
							state    <= LK_TX;
						end else begin
							sdaOeReg <= 1'b0;
							state    <= LK_RX;
						end
					end
				end
				LK_TX: begin
					if (sclRise) begin
						bitCnt <= bitCnt + 4'h1;
						if (role == ROLE_ARA && txByte[7] && !sdaS) begin
							state    <= LK_IDLE;
							sdaOeReg <= 1'b0;
						end
					end else if (byteDone) begin
						bitCnt   <= 4'h0;
						sdaOeReg <= 1'b0;
						state    <= LK_MACK;
						araWon   <= (role == ROLE_ARA);
					end else if (sclFall) begin
						txByte   <= {txByte[6:0], 1'b0};
						sdaOeReg <= ~txByte[6];
					end
				end
				LK_MACK: begin
					if (sclRise) begin
						masterAck <= ~sdaS;
					end else if (sclFall) begin
						if (masterAck && role == ROLE_READ) begin
							txByte   <= nextTx;
							sdaOeReg <= ~nextTx[7];
							byteIdx  <= byteIdx + 2'h1;
							state    <= LK_TX;
						end else begin
							state <= LK_IDLE;
						end
					end
				end
				default: begin
					sdaOeReg <= 1'b0;
				end
			endcase
		end
	end

	assign sdaOe  = sdaOeReg;
	assign hsMode = hsModeReg;

	// Open-drain data line: only ever pulled low.
	always_ff @(posedge linkClk) begin
		sdaOut <= 1'b0;
	end

	// Register image from the core, refreshed continuously.
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			snapReg <= '{TEMP_RESET, CFG_RESET, TLOW_RESET, THIGH_RESET, 1'b0, 1'b0};
		end else if (snapValid) begin
			snapReg <= snapIn;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossings between the two domains.

	tsc_event_type evIn;
	logic          evInValid;

	// Events are spaced by whole bus bytes, far longer than one handshake round trip.
	tsc_handshake #(.WIDTH($bits(tsc_event_type))) evXfer (
		.srcClk(linkClk), .srcRst(linkRst), .srcValid(evValidReg), .srcData(evDataReg),
		.srcReady(evReady), .dstClk(core_clk), .dstRst(rst), .dstValid(evInValid),
		.dstData(evIn)
	);

	tsc_snapshot_type snapOut;
	tsc_handshake #(.WIDTH($bits(tsc_snapshot_type))) snapXfer (
		.srcClk(core_clk), .srcRst(rst), .srcValid(1'b1), .srcData(snapOut),
		.srcReady(), .dstClk(linkClk), .dstRst(linkRst), .dstValid(snapValid),
		.dstData(snapIn)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Core side, clocked by core_clk.

	logic [2:0]         coreSync;
	logic [7:0]         cfgReg;
	logic [11:0]        tempReg, tlowReg, thighReg;
	logic               alertReg, causeReg, armHigh, oneShotPending;
	logic [2:0]         highCnt, lowCnt, highNext, lowNext, need;
	logic               hiTrip, loTrip, gcReset, cfgWrite, clearEv, sdEnter;
	tsc_conv_state_type convState;
	logic [TO_W-1:0]    toCnt;

	tsc_sync #(.WIDTH(3)) coreSyncInst (
		.clk(core_clk), .asyncIn({sclIn, sdaIn, busFrameReg}), .syncOut(coreSync)
	);

	assign snapOut  = '{tempReg, cfgReg, tlowReg, thighReg, alertReg, causeReg};
	assign gcReset  = evInValid && (evIn.kind == EV_GC_RESET);
	assign cfgWrite = evInValid && (evIn.kind == EV_WRITE) && (evIn.sel == SEL_CFG);
	assign sdEnter  = cfgWrite && evIn.data[8 + CFG_SD] && !cfgReg[CFG_SD];
	assign clearEv  = (evInValid && (evIn.kind == EV_READ || evIn.kind == EV_ARA_WON)) || sdEnter;

	// Fault counting against the fresh result; counts saturate at their width.
	assign need     = fault_need(cfgReg[CFG_FLT_HI:CFG_FLT_LO]);
	assign highNext = ($signed(convResult) >= $signed(thighReg))
		? ((highCnt == 3'h7) ? 3'h7 : highCnt + 3'h1) : 3'h0;
	assign lowNext  = ($signed(convResult) < $signed(tlowReg))
		? ((lowCnt == 3'h7) ? 3'h7 : lowCnt + 3'h1) : 3'h0;
	assign hiTrip   = convDone && (highNext >= need);
	assign loTrip   = convDone && (lowNext >= need);

	// Configuration and limit registers written from the bus.
	always_ff @(posedge core_clk) begin
		if (rst || gcReset) begin
			cfgReg   <= CFG_RESET;
			tlowReg  <= TLOW_RESET;
			thighReg <= THIGH_RESET;
		end else if (evInValid && evIn.kind == EV_WRITE) begin
			case (evIn.sel)
				SEL_CFG:   cfgReg   <= {1'b0, evIn.data[14:8]};
				SEL_TLOW:  tlowReg  <= evIn.data[15:4];
				SEL_THIGH: thighReg <= evIn.data[15:4];
				default:   cfgReg   <= cfgReg;
			endcase
		end
	end

	// Conversion sequencing: continuous, or single shots while shut down.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			convState      <= CV_IDLE;
			convStart      <= 1'b0;
			oneShotPending <= 1'b0;
		end else begin
			convStart <= 1'b0;
			if (cfgWrite && evIn.data[8 + CFG_OS] && evIn.data[8 + CFG_SD]) begin
				oneShotPending <= 1'b1;
			end else if (convState == CV_IDLE && oneShotPending) begin
				oneShotPending <= 1'b0;
			end
			case (convState)
				CV_IDLE: begin
					if (!cfgReg[CFG_SD] || oneShotPending) begin
						convStart <= 1'b1;
						convState <= CV_BUSY;
					end
				end
				CV_BUSY: begin
					if (convDone) begin
						convState <= CV_IDLE;
					end
				end
				default: convState <= CV_IDLE;
			endcase
		end
	end

	// Result register and consecutive fault counters.
	always_ff @(posedge core_clk) begin
		if (rst || gcReset) begin
			tempReg <= TEMP_RESET;
			highCnt <= 3'h0;
			lowCnt  <= 3'h0;
		end else if (convDone) begin
			tempReg <= convResult;
			highCnt <= highNext;
			lowCnt  <= lowNext;
		end
	end

	// Alert state; a trip in the same cycle as a clear keeps the alert set.
	always_ff @(posedge core_clk) begin
		if (rst || gcReset) begin
			alertReg <= 1'b0;
			causeReg <= 1'b0;
			armHigh  <= 1'b1;
		end else if (!cfgReg[CFG_TM]) begin
			armHigh <= 1'b1;
			if (hiTrip) begin
				alertReg <= 1'b1;
				causeReg <= 1'b1;
			end else if (loTrip) begin
				alertReg <= 1'b0;
				causeReg <= 1'b0;
			end
		end else if (armHigh && hiTrip) begin
			alertReg <= 1'b1;
			causeReg <= 1'b1;
			armHigh  <= 1'b0;
		end else if (!armHigh && loTrip) begin
			alertReg <= 1'b1;
			causeReg <= 1'b0;
			armHigh  <= 1'b1;
		end else if (clearEv) begin
			alertReg <= 1'b0;
		end
	end

	// Pin outputs; polarity zero makes the alert pin active low.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			alertPin      <= 1'b1;
			resolutionSel <= 2'h0;
		end else begin
			alertPin      <= cfgReg[CFG_POL] ? alertReg : ~alertReg;
			resolutionSel <= cfgReg[CFG_RES_HI:CFG_RES_LO];
		end
	end

	// Bus time-out: counting here keeps the long count on the known core rate.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			toCnt      <= '0;
			timeoutTgl <= 1'b0;
		end else if (coreSync[0] && (!coreSync[2] || !coreSync[1])) begin
			if (toCnt == TO_W'(TIMEOUT_CYCLES - 1)) begin
				toCnt      <= '0;
				timeoutTgl <= ~timeoutTgl;
			end else begin
				toCnt <= toCnt + 1'b1;
			end
		end else begin
			toCnt <= '0;
		end
	end
endmodule

// [tb/tsc_sensor_ctrl_assertions.sv]
// Port-level assertions for the temperature sensor control block.
module tsc_sensor_ctrl_assertions #(
	parameter int TIMEOUT_CYCLES = 1000
) (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       linkClk,
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOe,
	input wire logic       hsMode,
	input wire logic       convStart,
	input wire logic       convDone,
	input wire logic [1:0] resolutionSel,
	input wire logic       alertPin
);
	int lowCnt_reg;
	// Clock-line low time; it saturates so a long stall never wraps.
	always_ff @(posedge core_clk) begin
		if (rst || sclIn) begin
			lowCnt_reg <= 0;
		end else if (lowCnt_reg < TIMEOUT_CYCLES + 100) begin
			lowCnt_reg <= lowCnt_reg + 1;
		end
	end
	sequence s_stop;
		sclIn && $rose(sdaIn);
	endsequence
	property p_rst_vals;
		@(posedge core_clk) disable iff (rst) $fell(rst) |-> !convStart && !resolutionSel && alertPin;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values");
	property p_conv_first;
		@(posedge core_clk) disable iff (rst) $fell(rst) |-> ##[1:3] convStart;
	endproperty
	a_conv_first: assert property (p_conv_first) else $error("no first start");
	property p_conv_pulse;
		@(posedge core_clk) disable iff (rst) convStart |=> !convStart;
	endproperty
	a_conv_pulse: assert property (p_conv_pulse) else $error("long start");
	property p_one_conv;
		@(posedge core_clk) disable iff (rst) convStart |=> !convStart until convDone;
	endproperty
	a_one_conv: assert property (p_one_conv) else $error("overlapping start");
	property p_hs_stop;
		@(posedge linkClk) disable iff (rst) s_stop |-> ##[1:8] !hsMode;
	endproperty
	a_hs_stop: assert property (p_hs_stop) else $error("fast mode not restored");
	property p_hs_noack;
		@(posedge linkClk) disable iff (rst) $rose(hsMode) |-> !sdaOe;
	endproperty
	a_hs_noack: assert property (p_hs_noack) else $error("master code acked");
	property p_oe_scl;
		@(posedge linkClk) disable iff (rst) $changed(sdaOe) |-> !sclIn;
	endproperty
	a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
	property p_timeout;
		@(posedge core_clk) disable iff (rst) lowCnt_reg == TIMEOUT_CYCLES + 100 |-> !sdaOe;
	endproperty
	a_timeout: assert property (p_timeout) else $error("bus not released");
endmodule

// [tb/tsc_bm.sv]
// Behavioural two-wire bus master model for the sensor bench.
module tsc_bm (
	output logic      sclLow,
	output logic      sdaLow,
	input  wire logic sdaWire
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half bit time: about 780 kHz, far above the time-out floor.
	localparam int HALF = 640;
	initial begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end
	// START from idle, or repeated START from a low clock.
	task automatic start();
		#(HALF/2) sdaLow = 1'b0;
		#(HALF/2) sclLow = 1'b0;
		#HALF sdaLow = 1'b1;
		#HALF sclLow = 1'b1;
	endtask
	// STOP: data rises while the clock is high, then both lines idle.
	task automatic stop();
		#(HALF/2) sdaLow = 1'b1;
		#(HALF/2) sclLow = 1'b0;
		#HALF sdaLow = 1'b0;
		#HALF;
	endtask
	// Data moves mid-low so a bit never looks like START or STOP.
	task automatic clkBit(input logic b, output logic got);
		#(HALF/2) sdaLow = !b;
		#(HALF/2) sclLow = 1'b0;
		#(HALF/2) got = sdaWire;
		#(HALF/2) sclLow = 1'b1;
	endtask
	// Eight bits then the ninth; a released line reads high through the pull-up.
	task automatic xbyte(input logic [7:0] tx, input logic ninth, output logic [7:0] rx,
		output logic seen);
		for (int i = 7; i >= 0; i--) begin
			clkBit(tx[i], rx[i]);
		end
		clkBit(ninth, seen);
	endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the temperature sensor control block.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tsc_pkg::*;
	typedef struct packed {
		logic [7:0]  ptr;
		logic [1:0]  n;
		logic [15:0] d;
		logic [15:0] exp;
	} tsc_row_type;
	localparam int TOUT = 1000;
	logic        core_clk, rst, linkClk, sdaOut, sdaOe, hsMode, convStart, convDone;
	logic        sclLow, sdaLow, sclW, sdaW, alertPin, nk;
	logic [1:0]  resolutionSel;
	logic [2:0]  pins;
	logic [6:0]  a;
	logic [7:0]  rx;
	logic [11:0] convVal, convRes;
	logic [15:0] v;
	int          n_errors, n_checks, convLeft, nConv, n0;
	tsc_row_type rows [4];
	always #25 core_clk = ~core_clk;
	initial begin
		linkClk = 1'b0;
		#5;
		forever #16 linkClk = ~linkClk;
	end
	// Open-drain lines with pull-ups.
	assign sclW = !sclLow;
	assign sdaW = !(sdaLow || (sdaOe && !sdaOut));
	tsc_sensor_ctrl #(.TIMEOUT_CYCLES(TOUT)) u_tsc_sensor_ctrl (.core_clk(core_clk), .rst(rst),
		.linkClk(linkClk), .sclIn(sclW), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.addrPin0(pins[0]), .addrPin1(pins[1]), .addrPin2(pins[2]), .hsMode(hsMode),
		.convStart(convStart), .convDone(convDone), .convResult(convRes),
		.resolutionSel(resolutionSel), .alertPin(alertPin));
	tsc_bm u_tsc_bm (.sclLow(sclLow), .sdaLow(sdaLow), .sdaWire(sdaW));
	// Measurement stand-in: twenty cycles per conversion, result from convVal.
	always @(negedge core_clk) begin
		convRes <= convVal;
		convDone <= convLeft == 1 && !convStart;
		if (convStart) begin
			convLeft <= 20;
			nConv <= nConv + 1;
		end else if (convLeft != 0) begin
			convLeft <= convLeft - 1;
		end
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic put(input logic [7:0] b, input logic eNak);
		u_tsc_bm.xbyte(b, 1'b1, rx, nk);
		chk("ack", {15'h0, eNak}, {15'h0, nk});
	endtask
	// Write transfer left open so a repeated START may follow.
	task automatic wr(input logic [7:0] p, input logic [1:0] n, input logic [15:0] d);
		u_tsc_bm.start();
		put({a, 1'b0}, 1'b0);
		put(p, 1'b0);
		if (n > 0) put(d[15:8], 1'b0);
		if (n > 1) put(d[7:0], 1'b0);
	endtask
	task automatic rd(input logic eNak);
		u_tsc_bm.start();
		put({a, 1'b1}, eNak);
		u_tsc_bm.xbyte(8'hff, 1'b0, v[15:8], nk);
		u_tsc_bm.xbyte(8'hff, 1'b1, v[7:0], nk);
		u_tsc_bm.stop();
	endtask
	task automatic gc(input logic [7:0] cmd);
		u_tsc_bm.start();
		put(GC_BYTE, 1'b0);
		put(cmd, 1'b0);
		u_tsc_bm.stop();
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		#4_000_000;
		n_errors++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{core_clk, rst, convDone, pins} = 6'h10;
		{convVal, convRes} = {12'h190, 12'h190};
		a = {ADDR_BASE, 3'h0};
		rows = '{'{8'h03, 2'h2, 16'h6430, 16'h6430}, '{8'hfe, 2'h2, 16'h1af0, 16'h1af0},
			'{8'h01, 2'h1, 16'he000, 16'h6000}, '{8'h00, 2'h2, 16'h1234, 16'h1900}};
		repeat (10) @(negedge core_clk);
		rst = 1'b0;
		repeat (40) @(negedge core_clk);
		foreach (rows[i]) begin
			wr(rows[i].ptr, rows[i].n, rows[i].d);
			u_tsc_bm.stop();
			wr(rows[i].ptr, 2'h0, 16'h0);
			rd(1'b0);
			chk("read", rows[i].exp, v);
			rd(1'b0);
			chk("reread", rows[i].exp, v);
		end
		chk("resolution", 16'h3, {14'h0, resolutionSel});
		$display("done table");
		pins = 3'h5;
		gc(GC_CMD_LATCH);
		rd(1'b1);
		a = {ADDR_BASE, 3'h5};
		wr(8'h03, 2'h0, 16'h0);
		rd(1'b0);
		chk("kept", 16'h6430, v);
		gc(GC_CMD_RESET);
		wr(8'h03, 2'h0, 16'h0);
		rd(1'b0);
		chk("limit reset", {THIGH_RESET, 4'h0}, v);
		chk("res reset", 16'h0, {14'h0, resolutionSel});
		$display("done general call");
		convVal = THIGH_RESET;
		repeat (100) @(negedge core_clk);
		chk("alert high", 16'h0, {15'h0, alertPin});
		u_tsc_bm.start();
		put(ARA_BYTE, 1'b0);
		u_tsc_bm.xbyte(8'hff, 1'b1, rx, nk);
		u_tsc_bm.stop();
		chk("alert reply", {8'h0, a, 1'b1}, {8'h0, rx});
		convVal = TLOW_RESET;
		repeat (100) @(negedge core_clk);
		chk("alert at low", 16'h0, {15'h0, alertPin});
		convVal = TLOW_RESET - 12'h1;
		repeat (100) @(negedge core_clk);
		chk("alert off", 16'h1, {15'h0, alertPin});
		wr(8'h01, 2'h1, 16'h1600);
		u_tsc_bm.stop();
		convVal = THIGH_RESET;
		repeat (200) @(negedge core_clk);
		chk("int set", 16'h1, {15'h0, alertPin});
		rd(1'b0);
		chk("int cfg", 16'h1600, v);
		chk("int clear", 16'h0, {15'h0, alertPin});
		convVal = TLOW_RESET - 12'h1;
		repeat (200) @(negedge core_clk);
		chk("int low", 16'h1, {15'h0, alertPin});
		$display("done alert");
		wr(8'h01, 2'h1, 16'h0100);
		u_tsc_bm.stop();
		repeat (100) @(negedge core_clk);
		n0 = nConv;
		repeat (300) @(negedge core_clk);
		chk("halted", 16'h0, 16'(nConv - n0));
		wr(8'h01, 2'h1, 16'h8100);
		u_tsc_bm.stop();
		repeat (300) @(negedge core_clk);
		chk("one shot", 16'h1, 16'(nConv - n0));
		$display("done shutdown");
		u_tsc_bm.start();
		put(8'h0a, 1'b1);
		chk("hs on", 16'h1, {15'h0, hsMode});
		u_tsc_bm.start();
		put({a, 1'b0}, 1'b0);
		put(8'h01, 1'b0);
		u_tsc_bm.stop();
		repeat (20) @(negedge core_clk);
		chk("hs off", 16'h0, {15'h0, hsMode});
		u_tsc_bm.start();
		put({a, 1'b1}, 1'b0);
		#60000;
		chk("released", 16'h1, {15'h0, sdaW});
		u_tsc_bm.stop();
		$display("done bus modes");
		end_of_test();
	end
endmodule
bind tsc_sensor_ctrl tsc_sensor_ctrl_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.core_clk(core_clk), .rst(rst), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
	.sdaOe(sdaOe), .hsMode(hsMode), .convStart(convStart), .convDone(convDone),
	.resolutionSel(resolutionSel), .alertPin(alertPin));
